/* File: verilog/irl_top.sv */
// Purpose: Mode select, line control and fast-mode control registers of an infrared link.
// Assumes: AXI4-Lite master issues one write and one read at a time; core logic shares CLK_IN.
// Notes:   The core clock is gated outside; CORE_CLK_EN_OUT is the gate's enable.
//
// How it works
// - Setting the link enable releases the core reset and turns its clock on; clearing holds both off.
// - While the link is disabled the pulse output latch stays reset so the pin level holds.
// - With transmit unmask bit 7 set and the link enabled, a frame length write enters the transmit-enabled state, else not.
// - Receive enable bit 6 gates the receive line, data sampling and receive clocks.
// - Bit 5 set sends transmit data without 4PPM modulation, clear applies it.
// - Bit 4 set turns received-bit correction off, clear keeps it on.
// - Bit 2 clear appends a CRC to each frame, set omits it, and it resets to one.
// - Bit 1 set inverts the appended CRC, clear sends it unchanged.
// - Bit 0 set inverts receive and transmit line data; clear for fast mode, set for medium modes.
// - Line-control bits 15 to 8 and 3 read as zero and are written as zero.
`timescale 1ns/1ps
`default_nettype none
module irl_top
#(
  parameter int CRC_W = 32
)
(
  // Clock and reset
  input  wire logic             CLK_IN,
  input  wire logic             RSTN_IN,
  // AXI4-Lite write
  input  wire logic [31:0]      AWADDR_IN,
  input  wire logic             AWVALID_IN,
  output var  logic             AWREADY_OUT,
  input  wire logic [31:0]      WDATA_IN,
  input  wire logic [3:0]       WSTRB_IN,
  input  wire logic             WVALID_IN,
  output var  logic             WREADY_OUT,
  output var  logic [1:0]       BRESP_OUT,
  output var  logic             BVALID_OUT,
  input  wire logic             BREADY_IN,
  // AXI4-Lite read
  input  wire logic [31:0]      ARADDR_IN,
  input  wire logic             ARVALID_IN,
  output var  logic             ARREADY_OUT,
  output var  logic [31:0]      RDATA_OUT,
  output var  logic [1:0]       RRESP_OUT,
  output var  logic             RVALID_OUT,
  input  wire logic             RREADY_IN,
  // Core control
  output var  logic             CORE_RSTN_OUT,
  output var  logic             CORE_CLK_EN_OUT,
  output var  irl_pkg::irl_cfg_t CFG_OUT,
  output var  logic [15:0]      TX_LEN_OUT,
  output var  logic             TX_ENABLED_OUT,
  input  wire logic             TX_DONE_IN,
  output var  logic             RX_SAMPLE_EN_OUT,
  output var  logic             RX_CLK_EN_OUT,
  // Core data
  input  wire logic             TX_PULSE_IN,
  input  wire logic [CRC_W-1:0] CRC_IN,
  output var  logic [CRC_W-1:0] CRC_OUT,
  output var  logic             RX_BIT_OUT,
  // Transceiver pins
  input  wire logic             IR_RX_IN,
  output var  logic             IR_TX_OUT
);

  // ----------------------------------------------------------------
  // Decode and byte-lane helpers
  // ----------------------------------------------------------------
  function automatic irl_pkg::irl_sel_t decode(input logic [31:0] addr);
    if (addr == irl_pkg::ADDR_MODE)
      decode = irl_pkg::SEL_MODE;
    else if (addr == irl_pkg::ADDR_LINE)
      decode = irl_pkg::SEL_LINE;
    else if (addr == irl_pkg::ADDR_FAST)
      decode = irl_pkg::SEL_FAST;
    else if (addr == irl_pkg::ADDR_TXLEN)
      decode = irl_pkg::SEL_TXLEN;
    else if (addr == irl_pkg::ADDR_STATUS)
      decode = irl_pkg::SEL_STATUS;
    else
      decode = irl_pkg::SEL_NONE;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] new_val,
                                        input logic [1:0] strb, input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~lanes) | (new_val & lanes);
  endfunction

  logic [31:0]       aw_addr_r;
  logic              aw_held_r;
  logic [31:0]       w_data_r;
  logic [1:0]        w_strb_r;
  logic              w_held_r;
  logic              aw_hit;
  logic              w_hit;
  logic              wr_fire;
  logic [31:0]       wr_addr;
  logic [15:0]       wr_data;
  logic [1:0]        wr_strb;
  irl_pkg::irl_sel_t wr_sel;
  irl_pkg::irl_sel_t rd_sel;
  logic [15:0]       mode_r;
  logic [15:0]       line_r;
  logic [15:0]       fast_r;
  logic [15:0]       txlen_r;
  logic              len_wr;
  logic [15:0]       rd_val;
  logic              link_en;

  // ----------------------------------------------------------------
  // Write channel: address and data in either order
  // ----------------------------------------------------------------
  assign AWREADY_OUT = !aw_held_r && !BVALID_OUT;
  assign WREADY_OUT  = !w_held_r && !BVALID_OUT;
  assign aw_hit      = AWVALID_IN && AWREADY_OUT;
  assign w_hit       = WVALID_IN && WREADY_OUT;
  assign wr_fire     = (aw_held_r || aw_hit) && (w_held_r || w_hit);
  assign wr_addr     = aw_held_r ? aw_addr_r : AWADDR_IN;
  assign wr_data     = w_held_r ? w_data_r[15:0] : WDATA_IN[15:0];
  assign wr_strb     = w_held_r ? w_strb_r : WSTRB_IN[1:0];
  assign wr_sel      = decode(wr_addr);

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      aw_addr_r  <= 32'h0000_0000;
      aw_held_r  <= 1'b0;
      w_data_r   <= 32'h0000_0000;
      w_strb_r   <= 2'h0;
      w_held_r   <= 1'b0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= irl_pkg::RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_r  <= 1'b0;
        w_held_r   <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= (wr_sel == irl_pkg::SEL_NONE) ? irl_pkg::RESP_SLVERR : irl_pkg::RESP_OKAY;
      end
      else
      begin
        if (aw_hit)
        begin
          aw_addr_r <= AWADDR_IN;
          aw_held_r <= 1'b1;
        end
        if (w_hit)
        begin
          w_data_r <= WDATA_IN;
          w_strb_r <= WSTRB_IN[1:0];
          w_held_r <= 1'b1;
        end
        if (BVALID_OUT && BREADY_IN)
          BVALID_OUT <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      mode_r <= irl_pkg::MODE_RST;
    else if (wr_fire && wr_sel == irl_pkg::SEL_MODE)
      mode_r <= merge(mode_r, wr_data, wr_strb, irl_pkg::MODE_WMASK);
  end

  // Reserved bits are masked at write so they never hold a one
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      line_r <= irl_pkg::LINE_RST;
    else if (wr_fire && wr_sel == irl_pkg::SEL_LINE)
      line_r <= merge(line_r, wr_data, wr_strb, irl_pkg::LINE_WMASK);
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      fast_r <= irl_pkg::FAST_RST;
    else if (wr_fire && wr_sel == irl_pkg::SEL_FAST)
      fast_r <= merge(fast_r, wr_data, wr_strb, irl_pkg::FAST_WMASK);
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      txlen_r <= irl_pkg::TXLEN_RST;
    else if (len_wr)
      txlen_r <= merge(txlen_r, wr_data, wr_strb, 16'hFFFF);
  end

  assign len_wr  = wr_fire && (wr_sel == irl_pkg::SEL_TXLEN);
  assign link_en = mode_r[irl_pkg::MODE_LINK_EN];

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ARREADY_OUT = !RVALID_OUT;
  assign rd_sel      = decode(ARADDR_IN);

  always_comb
  begin
    rd_val = 16'h0000;
    case (rd_sel)
      irl_pkg::SEL_MODE:   rd_val = mode_r;
      irl_pkg::SEL_LINE:   rd_val = line_r;
      irl_pkg::SEL_FAST:   rd_val = {fast_r[15:5], irl_pkg::WIN_VALUE, fast_r[2:0]};
      irl_pkg::SEL_TXLEN:  rd_val = txlen_r;
      irl_pkg::SEL_STATUS:
      begin
        rd_val[irl_pkg::ST_TX_ENABLED] = TX_ENABLED_OUT;
        rd_val[irl_pkg::ST_LINK_EN]    = link_en;
      end
      default:             rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT  <= 32'h0000_0000;
      RRESP_OUT  <= irl_pkg::RESP_OKAY;
    end
    else if (ARVALID_IN && ARREADY_OUT)
    begin
      RVALID_OUT <= 1'b1;
      RDATA_OUT  <= {16'h0000, rd_val};
      RRESP_OUT  <= (rd_sel == irl_pkg::SEL_NONE) ? irl_pkg::RESP_SLVERR : irl_pkg::RESP_OKAY;
    end
    else if (RVALID_OUT && RREADY_IN)
      RVALID_OUT <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Core control and configuration
  // ----------------------------------------------------------------
  // Registered so the core reset releases cleanly one edge after the write
  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      CORE_RSTN_OUT   <= 1'b0;
      CORE_CLK_EN_OUT <= 1'b0;
    end
    else
    begin
      CORE_RSTN_OUT   <= link_en;
      CORE_CLK_EN_OUT <= link_en;
    end
  end

  assign CFG_OUT.mode = !mode_r[irl_pkg::MODE_HIGH] ? irl_pkg::MODE_FAST :
                        (mode_r[irl_pkg::MODE_LOW] ? irl_pkg::MODE_MED_HALF :
                                                     irl_pkg::MODE_MED_FULL);
  assign CFG_OUT.ppm_on           = !line_r[irl_pkg::LC_PPM_OFF];
  assign CFG_OUT.bit_corr_on      = !line_r[irl_pkg::LC_CORR_OFF];
  assign CFG_OUT.crc_append       = !line_r[irl_pkg::LC_CRC_OMIT];
  assign CFG_OUT.crc_invert       = line_r[irl_pkg::LC_CRC_CORR];
  assign CFG_OUT.line_invert      = line_r[irl_pkg::LC_INVERT];
  assign CFG_OUT.preamble_count   = fast_r[irl_pkg::FC_PRE_LSB +: 3];
  assign CFG_OUT.fast_pulse_width = fast_r[irl_pkg::FC_WIDTH_LSB +: 3];
  assign TX_LEN_OUT       = txlen_r;
  assign RX_SAMPLE_EN_OUT = link_en && line_r[irl_pkg::LC_RX_EN];
  assign RX_CLK_EN_OUT    = link_en && line_r[irl_pkg::LC_RX_EN];

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  irl_tx_gate u_tx_gate
  (
    .clk_in         (CLK_IN),
    .rstn_in        (RSTN_IN),
    .link_en_in     (link_en),
    .tx_unmask_in   (line_r[irl_pkg::LC_TX_UNMASK]),
    .len_wr_in      (len_wr),
    .tx_done_in     (TX_DONE_IN),
    .tx_enabled_out (TX_ENABLED_OUT)
  );

  irl_line_io #(.CRC_W(CRC_W)) u_line_io
  (
    .clk_in         (CLK_IN),
    .rstn_in        (RSTN_IN),
    .link_en_in     (link_en),
    .rx_en_in       (line_r[irl_pkg::LC_RX_EN]),
    .invert_in      (line_r[irl_pkg::LC_INVERT]),
    .crc_corrupt_in (line_r[irl_pkg::LC_CRC_CORR]),
    .tx_pulse_in    (TX_PULSE_IN),
    .crc_in         (CRC_IN),
    .rx_bit_out     (RX_BIT_OUT),
    .crc_out        (CRC_OUT),
    .rx_pin_in      (IR_RX_IN),
    .tx_pin_out     (IR_TX_OUT)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence s_mode_wr;
    wr_fire && wr_sel == irl_pkg::SEL_MODE && wr_strb[0];
  endsequence

  sequence s_line_wr;
    wr_fire && wr_sel == irl_pkg::SEL_LINE && wr_strb[0];
  endsequence

  property p_core_release;
    s_mode_wr and wr_data[7] |-> ##2 CORE_RSTN_OUT && CORE_CLK_EN_OUT;
  endproperty
  a_core_release: assert property (p_core_release) else $error("core not released after enable");

  property p_pin_hold;
    !link_en |=> !IR_TX_OUT;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("tx pin moved while disabled");

  property p_tx_arm;
    len_wr && line_r[7] && link_en |=> TX_ENABLED_OUT;
  endproperty
  a_tx_arm: assert property (p_tx_arm) else $error("frame length write did not arm transmit");

  property p_tx_mask;
    len_wr && !line_r[7] && !TX_ENABLED_OUT |=> !TX_ENABLED_OUT;
  endproperty
  a_tx_mask: assert property (p_tx_mask) else $error("masked transmit start armed");

  property p_rx_off;
    !line_r[6] |-> !RX_SAMPLE_EN_OUT && !RX_CLK_EN_OUT ##1 !RX_BIT_OUT;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receive active while disabled");

  property p_debug_bits;
    s_line_wr |=> CFG_OUT.ppm_on == !$past(wr_data[5]) && CFG_OUT.bit_corr_on == !$past(wr_data[4])
                  && CFG_OUT.crc_append == !$past(wr_data[2]);
  endproperty
  a_debug_bits: assert property (p_debug_bits) else $error("debug control not applied");

  property p_crc_corrupt;
    CFG_OUT.crc_invert |=> CRC_OUT == ~$past(CRC_IN);
  endproperty
  a_crc_corrupt: assert property (p_crc_corrupt) else $error("crc not inverted");

  property p_tx_invert;
    link_en && CFG_OUT.line_invert |=> IR_TX_OUT == !$past(TX_PULSE_IN);
  endproperty
  a_tx_invert: assert property (p_tx_invert) else $error("tx data not inverted");

  property p_line_reserved;
    ARVALID_IN && ARREADY_OUT && rd_sel == irl_pkg::SEL_LINE |=> RDATA_OUT[15:8] == 8'h00 && !RDATA_OUT[3];
  endproperty
  a_line_reserved: assert property (p_line_reserved) else $error("reserved line bits read nonzero");

  property p_fast_window;
    ARVALID_IN && ARREADY_OUT && rd_sel == irl_pkg::SEL_FAST |=> RDATA_OUT[4:3] == 2'h0;
  endproperty
  a_fast_window: assert property (p_fast_window) else $error("pulse window read wrong");

  property p_mode_decode;
    s_mode_wr |=> CFG_OUT.mode == ($past(wr_data[1]) ? ($past(wr_data[0]) ? irl_pkg::MODE_MED_HALF
                  : irl_pkg::MODE_MED_FULL) : irl_pkg::MODE_FAST);
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");

endmodule
`default_nettype wire

/* File: verilog/irl_pkg.sv */
// Purpose: Shared constants and types of the infrared link mode and line control block.
// Assumes: 32-bit AXI4-Lite register access, registers 16 bits wide in the low half of a word.
// Notes:   Printed offsets are register indices; the byte address is four times the index.
`default_nettype none
package irl_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_MODE   = 32'h0C00_0058;
  localparam logic [31:0] IDX_LINE   = 32'h0C00_005C;
  localparam logic [31:0] IDX_FAST   = 32'h0C00_005E;
  localparam logic [31:0] IDX_TXLEN  = 32'h0C00_0070;
  localparam logic [31:0] IDX_STATUS = 32'h0C00_0072;
  localparam logic [31:0] ADDR_MODE   = IDX_MODE * 4;
  localparam logic [31:0] ADDR_LINE   = IDX_LINE * 4;
  localparam logic [31:0] ADDR_FAST   = IDX_FAST * 4;
  localparam logic [31:0] ADDR_TXLEN  = IDX_TXLEN * 4;
  localparam logic [31:0] ADDR_STATUS = IDX_STATUS * 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_LINK_EN  = 7;
  localparam int MODE_HIGH     = 1;
  localparam int MODE_LOW      = 0;
  localparam int LC_TX_UNMASK  = 7;
  localparam int LC_RX_EN      = 6;
  localparam int LC_PPM_OFF    = 5;
  localparam int LC_CORR_OFF   = 4;
  localparam int LC_CRC_OMIT   = 2;
  localparam int LC_CRC_CORR   = 1;
  localparam int LC_INVERT     = 0;
  localparam int FC_PRE_LSB    = 5;
  localparam int FC_WIN_LSB    = 3;
  localparam int FC_WIDTH_LSB  = 0;
  localparam int ST_TX_ENABLED = 0;
  localparam int ST_LINK_EN    = 1;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] LINE_RST   = 16'h0004;
  localparam logic [15:0] FAST_RST   = 16'h0085;
  localparam logic [15:0] TXLEN_RST  = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h0083;
  localparam logic [15:0] LINE_WMASK = 16'h00F7;
  localparam logic [15:0] FAST_WMASK = 16'h00E7;
  localparam logic [1:0]  WIN_VALUE  = 2'h0;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FAST     = 2'b00,
    MODE_MED_FULL = 2'b01,
    MODE_MED_HALF = 2'b10
  } irl_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_MODE   = 3'b001,
    SEL_LINE   = 3'b010,
    SEL_FAST   = 3'b011,
    SEL_TXLEN  = 3'b100,
    SEL_STATUS = 3'b101
  } irl_sel_t;

  typedef enum logic {
    TXG_IDLE    = 1'b0,
    TXG_ENABLED = 1'b1
  } irl_txg_state_t;

  typedef struct packed {
    irl_mode_t mode;
    logic      ppm_on;
    logic      bit_corr_on;
    logic      crc_append;
    logic      crc_invert;
    logic      line_invert;
    logic [2:0] preamble_count;
    logic [2:0] fast_pulse_width;
  } irl_cfg_t;

endpackage
`default_nettype wire

/* File: verilog/irl_tx_gate.sv */
// Purpose: Transmit-enabled state entered by a frame length write.
// Assumes: Frame length write and done pulses come from logic on the same clock.
// Notes:   An unmasked write in the same cycle as done wins, so no armed frame is lost.
`timescale 1ns/1ps
`default_nettype none
module irl_tx_gate
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Control
  input  wire logic link_en_in,
  input  wire logic tx_unmask_in,
  input  wire logic len_wr_in,
  input  wire logic tx_done_in,
  // State
  output var  logic tx_enabled_out
);

  irl_pkg::irl_txg_state_t state_r;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      state_r <= irl_pkg::TXG_IDLE;
    else if (!link_en_in)
      state_r <= irl_pkg::TXG_IDLE;
    else
    begin
      case (state_r)
        irl_pkg::TXG_IDLE:
          if (len_wr_in && tx_unmask_in)
            state_r <= irl_pkg::TXG_ENABLED;
        irl_pkg::TXG_ENABLED:
          if (tx_done_in && !(len_wr_in && tx_unmask_in))
            state_r <= irl_pkg::TXG_IDLE;
        default:
          state_r <= irl_pkg::TXG_IDLE;
      endcase
    end
  end

  assign tx_enabled_out = (state_r == irl_pkg::TXG_ENABLED);

endmodule
`default_nettype wire

/* File: verilog/irl_line_io.sv */
// Purpose: Line-side pulse output latch, receive input path and CRC word shaping.
// Assumes: rx_pin_in is asynchronous; all other inputs are on clk_in.
// Notes:   Inversion sits before the latch so the pin holds still while disabled.
`timescale 1ns/1ps
`default_nettype none
module irl_line_io
#(
  parameter int CRC_W = 32
)
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Configuration
  input  wire logic             link_en_in,
  input  wire logic             rx_en_in,
  input  wire logic             invert_in,
  input  wire logic             crc_corrupt_in,
  // Core side
  input  wire logic             tx_pulse_in,
  input  wire logic [CRC_W-1:0] crc_in,
  output var  logic             rx_bit_out,
  output var  logic [CRC_W-1:0] crc_out,
  // Pins
  input  wire logic             rx_pin_in,
  output var  logic             tx_pin_out
);

  logic rx_meta_r;
  logic rx_sync_r;

  // ----------------------------------------------------------------
  // Transmit latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      tx_pin_out <= 1'b0;
    else if (!link_en_in)
      tx_pin_out <= 1'b0;
    else
      tx_pin_out <= tx_pulse_in ^ invert_in;
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rx_meta_r <= 1'b0;
      rx_sync_r <= 1'b0;
    end
    else
    begin
      rx_meta_r <= rx_pin_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rx_bit_out <= 1'b0;
    else if (!(link_en_in && rx_en_in))
      rx_bit_out <= 1'b0;
    else
      rx_bit_out <= rx_sync_r ^ invert_in;
  end

  // ----------------------------------------------------------------
  // CRC word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      crc_out <= '0;
    else
      crc_out <= crc_corrupt_in ? ~crc_in : crc_in;
  end

endmodule
`default_nettype wire

/* File: tb/irl_xcvr_model.sv */
// Purpose: Line-side transceiver model.
// Assumes: emit_in frames each received bit.
// Notes:   Idle line toggles so a stale level cannot pass.
`timescale 1ns/1ps
`default_nettype none
module irl_xcvr_model
(
  input  wire logic clk_in,
  input  wire logic emit_in,
  input  wire logic bit_in,
  output var  logic rx_out
);
  logic idle_r = 1'b0;
  always_ff @(posedge clk_in)
    idle_r <= ~idle_r;
  assign rx_out = emit_in ? bit_in : idle_r;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench of the link control block.
// Assumes: AXI4-Lite master, one transfer at a time.
// Notes:   Software sequences keep to the mode switch order.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic tx_done = 1'b0, tx_pulse = 1'b0, emit = 1'b0, rbit = 1'b0, ir_rx;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic [31:0] crc_in = 32'h1234_5678, rdata, crc_out, rd_v;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rsp;
  logic awr, wrdy, bvalid, arr, rvalid, c_rstn, c_clk, tx_en, rx_samp, rx_clk, rx_bit, ir_tx;
  logic [15:0] tx_len;
  irl_pkg::irl_cfg_t cfg;
  int err_total = 0;
  int n_checks = 0;
  irl_top i_irl_top (.CLK_IN(clk), .RSTN_IN(rstn), .AWADDR_IN(awaddr), .AWVALID_IN(awv), .AWREADY_OUT(awr),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wv), .WREADY_OUT(wrdy), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arv), .ARREADY_OUT(arr),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .CORE_RSTN_OUT(c_rstn),
    .CORE_CLK_EN_OUT(c_clk), .CFG_OUT(cfg), .TX_LEN_OUT(tx_len), .TX_ENABLED_OUT(tx_en), .TX_DONE_IN(tx_done),
    .RX_SAMPLE_EN_OUT(rx_samp), .RX_CLK_EN_OUT(rx_clk), .TX_PULSE_IN(tx_pulse), .CRC_IN(crc_in),
    .CRC_OUT(crc_out), .RX_BIT_OUT(rx_bit), .IR_RX_IN(ir_rx), .IR_TX_OUT(ir_tx));
  irl_xcvr_model i_irl_xcvr_model (.clk_in(clk), .emit_in(emit), .bit_in(rbit), .rx_out(ir_rx));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    rd(irl_pkg::ADDR_LINE);
    chk(rd_v, 32'h0000_0004);
    rd(irl_pkg::ADDR_FAST);
    chk(rd_v, 32'h0000_0085);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, irl_pkg::RESP_OKAY});
    chk({c_rstn, c_clk}, 32'h0000_0000);
    rd(irl_pkg::ADDR_LINE + 32'h0000_0004);
    chk(rd_v, 32'h0000_0000);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, irl_pkg::RESP_SLVERR});
    wr(irl_pkg::ADDR_LINE + 32'h0000_0004, 16'h0000);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, irl_pkg::RESP_SLVERR});
  endtask
  task automatic t_fields();
    wr(irl_pkg::ADDR_LINE, 16'hFFFF);
    rd(irl_pkg::ADDR_LINE);
    chk(rd_v, 32'h0000_00F7);
    chk({cfg.ppm_on, cfg.bit_corr_on, cfg.crc_append, cfg.crc_invert, cfg.line_invert}, 5'b00011);
    chk(crc_out, ~crc_in);
    wr(irl_pkg::ADDR_LINE, 16'h0000);
    chk({cfg.ppm_on, cfg.bit_corr_on, cfg.crc_append, cfg.crc_invert, cfg.line_invert}, 5'b11100);
    chk(crc_out, crc_in);
    wr(irl_pkg::ADDR_FAST, 16'hFFFF);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, irl_pkg::RESP_OKAY});
    rd(irl_pkg::ADDR_FAST);
    chk(rd_v, 32'h0000_00E7);
    chk({cfg.preamble_count, cfg.fast_pulse_width}, 6'h3F);
  endtask
  task automatic t_mode();
    for (int v = 0; v < 4; v++)
    begin
      wr(irl_pkg::ADDR_MODE, 16'(v));
      wr(irl_pkg::ADDR_LINE, 16'(v[1]));
      chk(cfg.mode, v[1] ? (v[0] ? irl_pkg::MODE_MED_HALF : irl_pkg::MODE_MED_FULL) : irl_pkg::MODE_FAST);
    end
    wr(irl_pkg::ADDR_MODE, 16'h0000);
    wr(irl_pkg::ADDR_LINE, 16'h0000);
    tx_pulse <= 1'b1;
    wr(irl_pkg::ADDR_MODE, 16'h0080);
    chk({c_rstn, c_clk, ir_tx}, 3'b111);
    wr(irl_pkg::ADDR_MODE, 16'h0000);
    chk({c_rstn, c_clk, ir_tx}, 3'b000);
    // Pulse low so an unheld latch would show the inverted level
    tx_pulse <= 1'b0;
    wr(irl_pkg::ADDR_MODE, 16'h0002);
    wr(irl_pkg::ADDR_LINE, 16'h0001);
    chk(ir_tx, 1'b0);
    wr(irl_pkg::ADDR_MODE, 16'h0082);
    chk({cfg.mode, ir_tx}, {irl_pkg::MODE_MED_FULL, 1'b1});
  endtask
  task automatic t_tx();
    wr(irl_pkg::ADDR_TXLEN, 16'h0010);
    chk({tx_len, tx_en}, {16'h0010, 1'b0});
    wr(irl_pkg::ADDR_LINE, 16'h0081);
    wr(irl_pkg::ADDR_TXLEN, 16'h0020);
    chk(tx_en, 1'b1);
    rd(irl_pkg::ADDR_STATUS);
    chk(rd_v, 32'h0000_0003);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    @(posedge clk);
    chk(tx_en, 1'b0);
  endtask
  task automatic t_rx();
    emit <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rbit <= (i == 0);
      // Line control only changes with the link disabled, mode stays medium
      if (i != 1)
      begin
        wr(irl_pkg::ADDR_MODE, 16'h0002);
        wr(irl_pkg::ADDR_LINE, (i == 0) ? 16'h0041 : 16'h0001);
        wr(irl_pkg::ADDR_MODE, 16'h0082);
      end
      repeat (4) @(posedge clk);
      chk({rx_samp, rx_clk, rx_bit}, (i == 0) ? 3'b110 : (i == 1) ? 3'b111 : 3'b000);
    end
    emit <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_mode();
    t_tx();
    t_rx();
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
